//--- bench/aop_host_model.sv
// aop_host_model: host that reads serial results and can supply the serial clock.
// assumes frame_marker is active high and bits are stable at the rising sclk edge.
`timescale 1ns/1ns
module aop_host_model (
    input  wire logic  run,
    input  wire logic  frame,
    input  wire logic  sclk,
    input  wire logic  sdo,
    output logic       sclk_host,
    output logic [15:0] word,
    output int         n_words
);
    int n_bits = 0;
    initial begin
        sclk_host = 1'h0;
        word = 16'h0;
        n_words = 0;
    end
    // 160 ns link clock, held low outside frames or while stalled
    always begin
        #80;
        sclk_host = (run && frame) ? ~sclk_host : 1'h0;
    end
    // msb first: every 16 rising edges close one word
    always @(posedge sclk) begin
        word = {word[14:0], sdo};
        n_bits = n_bits + 1;
        if (n_bits % 16 == 0) n_words = n_words + 1;
    end
endmodule : aop_host_model

//--- bench/tb_top.sv
// tb_top: self-checking bench for the converter output port over apb and its pins.
// assumes the host model answers on sclk only while a frame is marked.
`timescale 1ns/1ns
module tb_top;
    import aop_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, err;
    logic        swap = 0, fmt = 0, fast = 0, lowp = 0, ser = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] pins = 16'h0, data_o, oe_n, hword, w, q[$];
    logic        pready, pslverr, sclk_o, sclk_oe_n, sdo, fm, core_active, rate_alarm;
    wire         sclk_host;
    aop_mode_t   conv_mode, e;
    int          miscompares = 0, n_compared = 0, n_words, k = 0;
    time         t0;
    // each pin shows the device while it drives, the bench otherwise
    wire  [15:0] data_i = (pins & oe_n) | (data_o & ~oe_n);
    wire         sclk_i = sclk_oe_n ? sclk_host : sclk_o;
    always #2 pclk = ~pclk;
    aop_port #(.MAX_IDLE_NS(400)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .half_swap_select(swap),
        .output_format_select(fmt), .fast_rate_select(fast), .low_power_select(lowp),
        .port_type_select(ser), .data_i(data_i), .data_o(data_o), .data_oe_n(oe_n),
        .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .serial_result_out(sdo),
        .frame_marker(fm), .conv_mode(conv_mode), .core_active(core_active),
        .rate_alarm(rate_alarm));
    aop_host_model u_host (.run(run), .frame(fm), .sclk(sclk_i), .sdo(sdo),
        .sclk_host(sclk_host), .word(hword), .n_words(n_words));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; answer taken at the edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // let any frame end, then change straps {ser,lowp,fast,fmt,swap} and pins
    task automatic straps(input logic [4:0] s, input logic [15:0] p);
        repeat (80) @(posedge pclk);
        {ser, lowp, fast, fmt, swap} <= s;
        pins <= p;
        repeat (4) @(posedge pclk);
    endtask : straps
    task automatic take(input logic [15:0] x);
        k++;
        wait (n_words >= k);
        check(hword, x);
    endtask : take
    function automatic logic [15:0] shown(input logic [15:0] v, input logic f, input logic s);
        logic [15:0] t;
        t = f ? v : {~v[15], v[14:0]};
        return s ? {t[7:0], t[15:8]} : t;
    endfunction : shown
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // watchdog: far beyond the roughly 40 us the sequence needs
    initial begin
        #200000;
        miscompares++;
        $display("mismatch at %0t: timeout", $time);
        final_report();
    end
    initial begin
        void'($urandom(33));
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        // parallel: all swap/format pairs, sign-boundary words first, upper pwdata ignored
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : 16'($urandom);
            straps({3'h0, i[1:0]}, 16'h0);
            apb(1'h1, ADDR_RESULT, {16'hFFFF, w});
            repeat (4) @(posedge pclk);
            check(data_o, shown(w, i[1], i[0]));
            check(oe_n, 16'h0);
        end
        // conversion modes, idle alarm and activity; alarm cleared first each time
        for (int m = 0; m < 4; m++) begin
            straps({1'h0, m[1:0], 2'h0}, 16'h0);
            apb(1'h1, ADDR_CTRL, 32'h1);
            repeat (120) @(posedge pclk);
            apb(1'h0, ADDR_STATUS, 32'h0);
            e = (m == 1) ? AOP_FAST : (m == 2) ? AOP_LOWPWR : AOP_NORMAL;
            check(rd[1:0], e);
            check(conv_mode, e);
            check(rate_alarm, m == 1);
            check(core_active, m != 2);
        end
        apb(1'h0, 8'h0C, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        // serial, internal clock, shift during conversion, straight binary
        straps(5'h12, 16'h0080);
        w = 16'($urandom);
        apb(1'h1, ADDR_RESULT, {16'h0, w});
        check({oe_n, 15'h0, sclk_oe_n}, 32'hFFFF0000);
        take(w);
        // read after convert, divider pins at maximum, two's complement
        straps(5'h10, 16'h000C);
        w = 16'($urandom);
        t0 = $time;
        apb(1'h1, ADDR_RESULT, {16'h0, w});
        take({~w[15], w[14:0]});
        // divider 3 stretches each bit eightfold; undivided the frame ends far sooner
        check(($time - t0) > 15 * 2 * (SCLK_HALF_CYC << 3) * CLK_NS, 1'h1);
        // external clock: host stalls until the buffer is full, then drains it
        straps(5'h12, 16'h0010);
        for (int j = 0; j < 9; j++) begin
            q.push_back(16'($urandom));
            apb(1'h1, ADDR_RESULT, {16'h0, q[j]});
        end
        apb(1'h0, ADDR_STATUS, 32'h0);
        check(rd[11:8], 32'h8);
        check(sclk_oe_n, 1'h1);
        run <= 1'h1;
        while (q.size() > 0) take(q.pop_front());
        straps(5'h12, 16'h0030);
        check(fm, 1'h1);
        final_report();
    end
endmodule : tb_top

//--- logic/aop_fifo.sv
// aop_fifo: result buffer between the register port and the output port.
// assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/1ns
module aop_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    aop_stream_if.snk               in_s,
    aop_stream_if.src               out_s,
    output logic [$clog2(DEPTH):0]  level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg, wptr_next;
    logic [AW-1:0]    rptr_reg, rptr_next;
    logic [AW:0]      cnt_reg,  cnt_next;
    logic             push, pop;

    // honest flags: ready drops at full, which stalls the apb write
    assign in_s.ready  = (cnt_reg != FULL_CNT);
    assign out_s.valid = (cnt_reg != '0);
    assign out_s.data  = mem[rptr_reg];
    assign level       = cnt_reg;
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    // pointer and count update
    always_comb begin
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop  ? rptr_reg + 1'b1 : rptr_reg;
        cnt_next  = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
        end
    end

    // storage has no reset: contents are only read behind valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= in_s.data;
        end
    end
endmodule : aop_fifo

//--- logic/aop_pkg.sv
// aop_pkg: constants, field positions and types of the output port block.
// assumes a 250 MHz pclk; every time below is turned into cycles of that clock.
package aop_pkg;
    localparam int DATA_W     = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W      = 4;
    localparam int ADDR_W     = 8;
    localparam int CNT_W      = 16;
    localparam int BIT_W      = 5;

    // apb register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h08;

    // control and status fields
    localparam int CTRL_CLR_RATE = 0;
    localparam int ST_MODE_LSB   = 0;
    localparam int ST_SERIAL     = 2;
    localparam int ST_EXTCLK     = 3;
    localparam int ST_RATE       = 4;
    localparam int ST_BUSY       = 5;
    localparam int ST_LEVEL_LSB  = 8;

    // positions inside the synchronised input vector
    localparam int SY_SWAP    = 0;
    localparam int SY_FMT     = 1;
    localparam int SY_FAST    = 2;
    localparam int SY_LOWP    = 3;
    localparam int SY_SER     = 4;
    localparam int SY_PIN_LSB = 5;
    localparam int SY_SCLK    = 21;
    localparam int SY_W       = 22;

    // data pins that take a serial-port role
    localparam int PIN_DIV_LSB = 2;
    localparam int PIN_CLKSRC  = 4;
    localparam int PIN_POL     = 5;
    localparam int PIN_RDC     = 7;

    // timing
    localparam int CLK_NS        = 4;
    localparam int SCLK_HALF_NS  = 20;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_NS       = 750;
    localparam int CONV_CYC      = (CONV_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {AOP_NORMAL, AOP_FAST, AOP_LOWPWR} aop_mode_t;
    typedef enum logic [1:0] {SER_IDLE, SER_WAIT, SER_SHIFT} aop_ser_t;

    // output coding: straight binary as stored, or msb inverted for two's complement
    function automatic logic [DATA_W-1:0] aop_fmt(input logic [DATA_W-1:0] w,
                                                  input logic straight);
        aop_fmt = straight ? w : {~w[DATA_W-1], w[DATA_W-2:0]};
    endfunction : aop_fmt
endpackage : aop_pkg

//--- logic/aop_port.sv
// aop_port: mode straps, pin sharing and result output of a 16-bit converter port.
// assumes results are written over apb, straps and pins are asynchronous to pclk.
//
// Summary of operation
// - With half swap low the low result byte drives data[7:0], high byte data[15:8]; else swapped.
// - Format select high gives straight binary, low inverts the msb for two's complement.
// - Fast select high with low power low runs the fastest mode; the host must keep a minimum rate.
// - With fast select low no minimum conversion rate applies and accuracy holds.
// - Low power high with fast low enters reduced power, activity following the sample rate.
// - Port type low uses the parallel port, high the serial port with shared pins reassigned.
// - Data pins 0 and 1 carry result bits in parallel mode and float in serial mode.
// - Pins 2 and 3 are outputs in parallel mode and clock-divider inputs in serial read-after-convert.
// - In every other serial mode pins 2 and 3 float.
// - Pin 4 is an output in parallel mode, the clock source select in serial; low drives sclk out.
// - Clock source high takes sclk from the host as an input and shifts on its edges.
// - In parallel mode pin 5 drives result bit 5.
// - In serial mode pin 5 sets the frame marker polarity: low active high, high active low.
// - With internal clock, read timing high shifts during conversion, low only after it.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module aop_port #(
    parameter int MAX_IDLE_NS = 1000000
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [aop_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         half_swap_select,
    input  wire logic                         output_format_select,
    input  wire logic                         fast_rate_select,
    input  wire logic                         low_power_select,
    input  wire logic                         port_type_select,
    input  wire logic [aop_pkg::DATA_W-1:0]   data_i,
    output logic      [aop_pkg::DATA_W-1:0]   data_o,
    output logic      [aop_pkg::DATA_W-1:0]   data_oe_n,
    input  wire logic                         sclk_i,
    output logic                              sclk_o,
    output logic                              sclk_oe_n,
    output logic                              serial_result_out,
    output logic                              frame_marker,
    output aop_pkg::aop_mode_t                conv_mode,
    output logic                              core_active,
    output logic                              rate_alarm
);
    import aop_pkg::*;

    localparam int IDLE_CYC = MAX_IDLE_NS / CLK_NS;
    localparam int CONV_CHK = CONV_CYC;

    aop_stream_if #(.W(DATA_W)) in_if ();
    aop_stream_if #(.W(DATA_W)) out_if ();
    logic [LVL_W-1:0] level;

    aop_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk   (pclk),
        .rst_n (presetn),
        .in_s  (in_if),
        .out_s (out_if),
        .level (level)
    );

    // two-stage synchroniser for straps, shared pins and the host sclk
    logic [SY_W-1:0] sync1_reg, sync2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {sclk_i, data_i, port_type_select, low_power_select,
                          fast_rate_select, output_format_select, half_swap_select};
            sync2_reg <= sync1_reg;
        end
    end

    // decoded straps, all taken from the second stage
    logic                s_swap, s_fmt, s_fast, s_lowp, s_ser, s_sclk;
    logic [DATA_W-1:0]   pin;
    logic                clk_ext, pol, rdc, rd_after;
    logic [1:0]          div;
    assign s_swap   = sync2_reg[SY_SWAP];
    assign s_fmt    = sync2_reg[SY_FMT];
    assign s_fast   = sync2_reg[SY_FAST];
    assign s_lowp   = sync2_reg[SY_LOWP];
    assign s_ser    = sync2_reg[SY_SER];
    assign s_sclk   = sync2_reg[SY_SCLK];
    assign pin      = sync2_reg[SY_PIN_LSB +: DATA_W];
    assign clk_ext  = s_ser && pin[PIN_CLKSRC];
    // pin 5 is a data output in parallel mode, so only serial mode reads it as polarity
    assign pol      = s_ser && pin[PIN_POL];
    assign rdc      = pin[PIN_RDC];
    assign rd_after = s_ser && !clk_ext && !rdc;
    assign div      = rd_after ? pin[PIN_DIV_LSB +: 2] : 2'h0;

    // registered state
    aop_ser_t          ser_state_reg, ser_state_next;
    aop_mode_t         mode_reg, mode_next;
    logic [BIT_W-1:0]  bit_cnt_reg, bit_cnt_next;
    logic [DATA_W-1:0] shreg_reg, shreg_next;
    logic [CNT_W-1:0]  wait_cnt_reg, wait_cnt_next;
    logic [CNT_W-1:0]  half_cnt_reg, half_cnt_next;
    logic [31:0]       idle_cnt_reg, idle_cnt_next;
    logic [DATA_W-1:0] data_o_reg, data_o_next;
    logic [DATA_W-1:0] data_oe_n_reg, data_oe_n_next;
    logic              sclk_o_reg, sclk_o_next;
    logic              sclk_oe_n_reg, sclk_oe_n_next;
    logic              sdo_reg, sdo_next;
    logic              frame_reg, frame_next;
    logic              core_reg, core_next;
    logic              rate_reg, rate_next;
    logic              sclk_d_reg;
    logic              pready_reg, pready_next;
    logic              pslverr_reg, pslverr_next;
    logic [31:0]       prdata_reg, prdata_next;

    // apb decode and answer: pready rises one cycle into the access phase
    logic        acc, fin, is_res, is_st, is_ctl, hold, clr_rate;
    logic [31:0] status_w;
    always_comb begin
        acc    = psel && penable && !pready_reg;
        fin    = psel && penable && pready_reg;
        is_res = 1'b0;
        is_st  = 1'b0;
        is_ctl = 1'b0;
        if (paddr == ADDR_RESULT) begin
            is_res = 1'b1;
        end else if (paddr == ADDR_STATUS) begin
            is_st = 1'b1;
        end else if (paddr == ADDR_CTRL) begin
            is_ctl = 1'b1;
        end
        // a result write waits while the buffer is full
        hold         = acc && is_res && pwrite && !in_if.ready;
        pready_next  = acc && !hold;
        pslverr_next = acc && !hold && !(is_res || is_st || is_ctl);
        status_w                           = '0;
        status_w[ST_MODE_LSB +: 2]         = mode_reg;
        status_w[ST_SERIAL]                = s_ser;
        status_w[ST_EXTCLK]                = clk_ext;
        status_w[ST_RATE]                  = rate_reg;
        status_w[ST_BUSY]                  = (ser_state_reg != SER_IDLE);
        status_w[ST_LEVEL_LSB +: LVL_W]    = level;
        prdata_next = prdata_reg;
        if (acc && !hold && !pwrite) begin
            prdata_next = is_st ? status_w : 32'h0000_0000;
        end
        clr_rate = fin && pwrite && is_ctl && pwdata[CTRL_CLR_RATE];
    end

    // a result enters the buffer at the edge that completes its write
    assign in_if.valid = fin && pwrite && is_res;
    assign in_if.data  = pwdata[DATA_W-1:0];

    // output port: parallel word, serial shifter, pin directions, modes
    logic              fall_ext, pop_par, pop_ser;
    logic [DATA_W-1:0] fw;
    logic [CNT_W-1:0]  half_lim;
    always_comb begin
        fw             = aop_fmt(out_if.data, s_fmt);
        fall_ext       = sclk_d_reg && !s_sclk;
        half_lim       = CNT_W'(SCLK_HALF_CYC) << div;
        pop_par        = !s_ser && out_if.valid;
        pop_ser        = s_ser && out_if.valid && (ser_state_reg == SER_IDLE);
        out_if.ready   = pop_par || pop_ser;
        ser_state_next = ser_state_reg;
        bit_cnt_next   = bit_cnt_reg;
        shreg_next     = shreg_reg;
        wait_cnt_next  = wait_cnt_reg;
        half_cnt_next  = half_cnt_reg;
        sclk_o_next    = sclk_o_reg;
        data_o_next    = data_o_reg;
        if (pop_par) begin
            data_o_next = s_swap ? {fw[7:0], fw[15:8]} : fw;
        end
        case (ser_state_reg)
            SER_IDLE: begin
                if (pop_ser) begin
                    shreg_next    = fw;
                    bit_cnt_next  = '0;
                    half_cnt_next = '0;
                    wait_cnt_next = CNT_W'(CONV_CYC - 1);
                    // read after convert holds off until the conversion ends
                    ser_state_next = rd_after ? SER_WAIT : SER_SHIFT;
                end
            end
            SER_WAIT: begin
                if (wait_cnt_reg == '0) begin
                    ser_state_next = SER_SHIFT;
                end else begin
                    wait_cnt_next = wait_cnt_reg - 1'b1;
                end
            end
            SER_SHIFT: begin
                if (clk_ext) begin
                    // host clock: next bit after each falling edge
                    if (fall_ext) begin
                        if (bit_cnt_reg == BIT_W'(DATA_W - 1)) begin
                            ser_state_next = SER_IDLE;
                        end else begin
                            bit_cnt_next = bit_cnt_reg + 1'b1;
                            shreg_next   = shreg_reg << 1;
                        end
                    end
                end else if (half_cnt_reg == half_lim - 1'b1) begin
                    half_cnt_next = '0;
                    sclk_o_next   = !sclk_o_reg;
                    if (sclk_o_reg) begin
                        if (bit_cnt_reg == BIT_W'(DATA_W - 1)) begin
                            ser_state_next = SER_IDLE;
                        end else begin
                            bit_cnt_next = bit_cnt_reg + 1'b1;
                            shreg_next   = shreg_reg << 1;
                        end
                    end
                end else begin
                    half_cnt_next = half_cnt_reg + 1'b1;
                end
            end
            default: begin
                ser_state_next = SER_IDLE;
            end
        endcase
        // leaving serial mode abandons a frame in progress
        if (!s_ser) begin
            ser_state_next = SER_IDLE;
        end
        if (ser_state_next != SER_SHIFT) begin
            sclk_o_next = 1'b0;
        end
        sdo_next       = shreg_next[DATA_W-1];
        frame_next     = (ser_state_next == SER_SHIFT) ^ pol;
        // serial mode floats every data pin; the shared ones are read as inputs
        data_oe_n_next = s_ser ? '1 : '0;
        sclk_oe_n_next = !(s_ser && !clk_ext);
        // fast needs low power off; both high falls back to normal
        if (s_fast && !s_lowp) begin
            mode_next = AOP_FAST;
        end else if (s_lowp && !s_fast) begin
            mode_next = AOP_LOWPWR;
        end else begin
            mode_next = AOP_NORMAL;
        end
        // reduced power: the core is only woken while a result is handled;
        // a word still waiting behind a frame counts as handled
        core_next = (mode_next != AOP_LOWPWR) || out_if.valid
                    || (ser_state_next != SER_IDLE);
        // minimum rate watch, only meaningful in the fastest mode
        idle_cnt_next = idle_cnt_reg;
        if (in_if.valid || mode_reg != AOP_FAST) begin
            idle_cnt_next = '0;
        end else if (idle_cnt_reg != 32'(IDLE_CYC)) begin
            idle_cnt_next = idle_cnt_reg + 1'b1;
        end
        rate_next = rate_reg;
        if (clr_rate) begin
            rate_next = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (mode_reg == AOP_FAST && idle_cnt_reg == 32'(IDLE_CYC)) begin
            rate_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_state_reg <= SER_IDLE;
            mode_reg      <= AOP_NORMAL;
            bit_cnt_reg   <= '0;
            shreg_reg     <= '0;
            wait_cnt_reg  <= '0;
            half_cnt_reg  <= '0;
            idle_cnt_reg  <= '0;
            data_o_reg    <= '0;
            data_oe_n_reg <= '1;
            sclk_o_reg    <= 1'b0;
            sclk_oe_n_reg <= 1'b1;
            sdo_reg       <= 1'b0;
            frame_reg     <= 1'b0;
            core_reg      <= 1'b0;
            rate_reg      <= 1'b0;
            sclk_d_reg    <= 1'b0;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            prdata_reg    <= '0;
        end else begin
            ser_state_reg <= ser_state_next;
            mode_reg      <= mode_next;
            bit_cnt_reg   <= bit_cnt_next;
            shreg_reg     <= shreg_next;
            wait_cnt_reg  <= wait_cnt_next;
            half_cnt_reg  <= half_cnt_next;
            idle_cnt_reg  <= idle_cnt_next;
            data_o_reg    <= data_o_next;
            data_oe_n_reg <= data_oe_n_next;
            sclk_o_reg    <= sclk_o_next;
            sclk_oe_n_reg <= sclk_oe_n_next;
            sdo_reg       <= sdo_next;
            frame_reg     <= frame_next;
            core_reg      <= core_next;
            rate_reg      <= rate_next;
            sclk_d_reg    <= s_sclk;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            prdata_reg    <= prdata_next;
        end
    end

    // every output straight from its flip-flop
    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign data_o            = data_o_reg;
    assign data_oe_n         = data_oe_n_reg;
    assign sclk_o            = sclk_o_reg;
    assign sclk_oe_n         = sclk_oe_n_reg;
    assign serial_result_out = sdo_reg;
    assign frame_marker      = frame_reg;
    assign conv_mode         = mode_reg;
    assign core_active       = core_reg;
    assign rate_alarm        = rate_reg;

    // checks on the driven outputs and the serial state
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait_start;
        pop_ser && rd_after;
    endsequence
    sequence s_now_start;
        pop_ser && !rd_after;
    endsequence

    a_byte_order: assert property (pop_par |=> data_o_reg ==
        ($past(s_swap) ? {$past(fw[7:0]), $past(fw[15:8])} : $past(fw)))
        else $error("parallel byte placement wrong");
    a_msb_coding: assert property (pop_par && !s_swap |=>
        data_o_reg[DATA_W-1] == ($past(out_if.data[DATA_W-1]) ^ !$past(s_fmt)))
        else $error("msb coding wrong");
    a_fast_mode: assert property (s_fast && !s_lowp |=> conv_mode == AOP_FAST)
        else $error("fast mode not entered");
    a_rate_only_fast: assert property ($rose(rate_reg) |-> $past(mode_reg) == AOP_FAST)
        else $error("rate alarm outside fast mode");
    a_low_power: assert property (s_lowp && !s_fast |=>
        conv_mode == AOP_LOWPWR ##1 (core_active || !$past(out_if.valid)))
        else $error("reduced power mode wrong");
    a_serial_float: assert property (s_ser |=> data_oe_n == '1)
        else $error("data pins driven in serial mode");
    a_parallel_drive: assert property (!s_ser |=> data_oe_n == '0)
        else $error("data pins floating in parallel mode");
    a_int_clk_out: assert property (s_ser && !clk_ext |=> !sclk_oe_n)
        else $error("internal sclk not driven");
    a_ext_clk_in: assert property (clk_ext |=> sclk_oe_n ##0
        (!(ser_state_reg == SER_SHIFT) || sclk_o == 1'b0))
        else $error("external sclk pin driven");
    a_frame_pol: assert property (##1 frame_marker ==
        ((ser_state_reg == SER_SHIFT) ^ $past(pol)))
        else $error("frame marker polarity wrong");
    a_read_after: assert property (s_wait_start |=> ser_state_reg == SER_WAIT
        ##CONV_CHK ser_state_reg == SER_SHIFT)
        else $error("read after convert timing wrong");
    a_read_during: assert property (s_now_start |=> ser_state_reg == SER_SHIFT)
        else $error("read during convert did not start");
    a_normal_mode: assert property (!s_fast && !s_lowp |=> conv_mode == AOP_NORMAL)
        else $error("normal mode not entered");
endmodule : aop_port

//--- logic/aop_stream_if.sv
// aop_stream_if: valid/ready word stream between the block's own modules.
// assumes both ends run on the same clock.
`timescale 1ns/1ns
interface aop_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : aop_stream_if
